//--- brownout_pkg.sv
// Purpose: constants for the brown-out detector register and monitor block
// Assumes: 4-bit byte offsets on a plain register port, 8-bit data
// Notes:   no module here, shared by the block and its testbench
package brownout_pkg;
  // register offsets
  localparam logic [3:0] OFS_MODE_CTRL  = 4'h0;
  localparam logic [3:0] OFS_THRESH     = 4'h1;
  localparam logic [3:0] OFS_MON_THRESH = 4'h8;
  localparam logic [3:0] OFS_IRQ_CTRL   = 4'h9;
  localparam logic [3:0] OFS_IRQ_FLAGS  = 4'ha;
  localparam logic [3:0] OFS_MON_STATE  = 4'hb;
  // detector operating modes
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_CONT      = 2'h1;
  localparam logic [1:0] MODE_SAMPLED   = 2'h2;
  // monitor trigger codes
  localparam logic [1:0] TRIG_BELOW     = 2'h0;
  localparam logic [1:0] TRIG_ABOVE     = 2'h1;
  localparam logic [1:0] TRIG_CROSS     = 2'h2;
  // field positions
  localparam int         IE_BIT         = 0;
  localparam int         FLAG_BIT       = 0;
  localparam int         TRIG_LSB       = 1;
  localparam int         TRIG_MSB       = 2;
  // reset values and unlock window in cycles
  localparam logic [1:0] MON_OFS_RST    = 2'h0;
  localparam logic [1:0] TRIG_RST       = 2'h0;
  localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
  localparam logic [7:0] READ_ZERO      = 8'h00;
endpackage

//--- brownout_level_monitor_ctrl.sv
// Purpose: registers, sync and interrupt for the brown-out detector
//          and its early-warning level monitor
// Assumes: fuse values are stable while rst is high; unlock key and
//          sleep request come from logic on clk
// Notes:   comparator output is asynchronous and is synchronised here
//          reserved sleep code 3 runs the detector continuously, the
//          safer reading of a reserved code
//          the unlock window counts clk cycles, one per instruction
`timescale 1ns/10ps
module brownout_level_monitor_ctrl (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // fuse loader, sampled while rst is high
  input  wire logic [1:0] fuse_active_mode,
  input  wire logic [1:0] fuse_sleep_mode,
  input  wire logic       fuse_sampfreq,
  input  wire logic [2:0] fuse_level,
  // cpu side controls
  input  wire logic       unlock_key,
  input  wire logic       sleep_deep,
  // analog side
  input  wire logic       comp_below_async,
  input  wire logic       sample_tick,
  output logic      [1:0] detector_mode,
  output logic            detector_sampfreq,
  output logic      [2:0] detector_level,
  output logic      [1:0] monitor_offset,
  output logic            monitor_run,
  // interrupt
  output logic            irq
);

  // all state of the block
  typedef struct packed {
    logic [1:0] sleep_mode;
    logic [1:0] active_mode;
    logic       sampfreq;
    logic [2:0] level;
    logic [1:0] offset;
    logic [1:0] trig;
    logic       ie;
    logic       flag;
    logic       sync1;
    logic       sync2;
    logic       below;
    logic [2:0] unlock_cnt;
    logic [7:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;

  // decode of the state and this cycle's inputs
  logic [1:0] eff_mode;
  logic       det_on;
  logic       det_cont;
  logic       take;
  logic       rise_below;
  logic       rise_above;
  logic       set_ev;
  logic       clr_ev;

  // mode in force follows the sleep state; reserved code 3 counts as
  // continuous so that a reserved code never silently disarms the detector
  always_comb begin
    eff_mode = sleep_deep ? st.sleep_mode
                          : st.active_mode;
    det_on   = (eff_mode != brownout_pkg::MODE_OFF);
    det_cont = det_on && (eff_mode != brownout_pkg::MODE_SAMPLED);
    // sampled detector only looks at the comparator on a sample
    take     = det_cont || (det_on && sample_tick);
  end

  // crossings of the monitor threshold seen at the update
  always_comb begin
    // both edges need take, so an idle detector never flags
    rise_below = take && st.sync2 && !st.below;
    rise_above = take && !st.sync2 && st.below;
    case (st.trig)
      brownout_pkg::TRIG_BELOW: set_ev = rise_below;
      brownout_pkg::TRIG_ABOVE: set_ev = rise_above;
      brownout_pkg::TRIG_CROSS: set_ev = rise_below || rise_above;
      default:                  set_ev = 1'b0; // reserved code is quiet
    endcase
    clr_ev = wr && (addr == brownout_pkg::OFS_IRQ_FLAGS)
                && wdata[brownout_pkg::FLAG_BIT];
  end

  // next state
  always_comb begin
    next_st = st;
    // two-stage synchroniser, first stage feeds only the second
    next_st.sync1 = comp_below_async;
    next_st.sync2 = st.sync1;
    // a sampled detector keeps its last reading between sample moments
    if (take) begin
      next_st.below = st.sync2;
    end
    // flag: set beats a write-one clear
    if (set_ev) begin
      next_st.flag = 1'b1;
    end else if (clr_ev) begin
      next_st.flag = 1'b0;
    end
    // unlock window counts down after the key
    // a second key reloads the full window even while one is open
    if (unlock_key) begin
      next_st.unlock_cnt = brownout_pkg::UNLOCK_CYCLES;
    end else if (st.unlock_cnt != 3'h0) begin
      next_st.unlock_cnt = st.unlock_cnt - 3'h1;
    end
    // register writes
    // offsets 1 and b are read-only and fall through to the default
    if (wr) begin
      case (addr)
        brownout_pkg::OFS_MODE_CTRL: begin
          if (st.unlock_cnt != 3'h0) begin
            next_st.sleep_mode = wdata[1:0];
            next_st.unlock_cnt = 3'h0;       // one write per key
          end
        end
        brownout_pkg::OFS_MON_THRESH: begin
          next_st.offset = wdata[1:0];
        end
        brownout_pkg::OFS_IRQ_CTRL: begin
          next_st.ie   = wdata[brownout_pkg::IE_BIT];
          next_st.trig = wdata[brownout_pkg::TRIG_MSB:
                               brownout_pkg::TRIG_LSB];
        end
        default: begin
        end
      endcase
    end
    // register reads, data in the following cycle
    // unmapped offsets and unused upper bits read as zero
    next_st.rdata = brownout_pkg::READ_ZERO;
    if (rd) begin
      case (addr)
        brownout_pkg::OFS_MODE_CTRL:
          next_st.rdata = {3'h0, st.sampfreq, st.active_mode,
                           st.sleep_mode};
        brownout_pkg::OFS_THRESH:
          next_st.rdata = {5'h00, st.level};
        brownout_pkg::OFS_MON_THRESH:
          next_st.rdata = {6'h00, st.offset};
        brownout_pkg::OFS_IRQ_CTRL:
          next_st.rdata = {5'h00, st.trig, st.ie};
        brownout_pkg::OFS_IRQ_FLAGS:
          next_st.rdata = {7'h00, st.flag};
        brownout_pkg::OFS_MON_STATE:
          next_st.rdata = {7'h00, st.below};
        default:
          next_st.rdata = brownout_pkg::READ_ZERO;
      endcase
    end
    // synchronous reset takes fuse values, not constants, for the modes
    if (rst) begin
      next_st             = '0;
      next_st.sleep_mode  = fuse_sleep_mode;
      next_st.active_mode = fuse_active_mode;
      next_st.sampfreq    = fuse_sampfreq;
      next_st.level       = fuse_level;
      next_st.offset      = brownout_pkg::MON_OFS_RST;
      next_st.trig        = brownout_pkg::TRIG_RST;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // outputs, data from flip-flops except detector_mode and monitor_run, which also decode sleep_deep
  assign rdata             = st.rdata;
  assign detector_mode     = eff_mode;
  assign detector_sampfreq = st.sampfreq;
  assign detector_level    = st.level;
  assign monitor_offset    = st.offset;
  // monitor_run powers the level comparator only while it can matter
  assign monitor_run       = det_on && st.ie;
  // level request while enabled and flagged
  assign irq               = st.flag && st.ie;

  // checks, all on clk and at rest while rst is high
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // the request may only drop through a clear or a new enable write
  a_irq_stays_high: assert property (
    (st.flag && st.ie && !clr_ev && !(wr && addr ==
      brownout_pkg::OFS_IRQ_CTRL)) |=> irq)
    else $error("irq dropped while flag and enable set");

  // an idle detector never raises the flag
  a_flag_frozen_off: assert property (
    !det_on |=> !$rose(st.flag))
    else $error("flag set while detector off");

  // threshold code is fuse-loaded and read-only
  a_level_fixed: assert property (
    1'b1 |=> $stable(st.level))
    else $error("threshold select changed outside reset");

  // a locked sleep field shrugs off mode writes
  a_sleep_locked: assert property (
    (wr && addr == brownout_pkg::OFS_MODE_CTRL
        && st.unlock_cnt == 3'h0) |=> $stable(st.sleep_mode))
    else $error("sleep mode written without unlock");

  // writing one clears when no event competes
  a_w1c_clears: assert property (
    (clr_ev && !set_ev) |=> !st.flag)
    else $error("write one did not clear flag");

  // an event always lands, even beside a clear
  a_set_wins: assert property (
    set_ev |=> st.flag)
    else $error("crossing event lost");

  // comparator to status is three edges; four cycles keep a reset that
  // cleared the chain out of reach
  a_sync_delay: assert property (
    det_cont [*4] |-> st.below == $past(comp_below_async, 3))
    else $error("status not three cycles behind comparator");

  // threshold reads back with the upper bits zero
  a_thresh_read: assert property (
    (rd && addr == brownout_pkg::OFS_THRESH)
      |=> rdata == {5'h00, st.level})
    else $error("threshold read wrong");

  // an idle detector leaves the status alone
  a_monitor_off: assert property (
    !det_on |=> $stable(st.below))
    else $error("status moved while detector off");

  // monitor path, register and unlock window checks

  // a sampled detector holds its status between sample moments
  a_sampled_hold: assert property (
    (det_on && !det_cont && !sample_tick)
      |=> $stable(st.below))
    else $error("status moved between sample moments");

  // and takes the synchronised comparator on a sample moment
  a_sampled_take: assert property (
    (det_on && !det_cont && sample_tick)
      |=> st.below == $past(st.sync2))
    else $error("status missed a sample moment");

  // a continuous detector updates the status on every edge
  a_cont_tracks: assert property (
    det_cont |=> st.below == $past(st.sync2))
    else $error("status lags the synchroniser");

  // the status register reads the live status bit
  a_state_read: assert property (
    (rd && addr == brownout_pkg::OFS_MON_STATE)
      |=> rdata == {7'h00, $past(st.below)})
    else $error("status read wrong");

  // the flag register reads the flag as it stood at the request
  a_flag_read: assert property (
    (rd && addr == brownout_pkg::OFS_IRQ_FLAGS)
      |=> rdata == {7'h00, $past(st.flag)})
    else $error("flag read wrong");

  // the interrupt control register reads back trigger and enable
  a_ctrl_read: assert property (
    (rd && addr == brownout_pkg::OFS_IRQ_CTRL)
      |=> rdata == {5'h00, $past(st.trig), $past(st.ie)})
    else $error("interrupt control read wrong");

  // the offset register reads back the offset field
  a_offset_read: assert property (
    (rd && addr == brownout_pkg::OFS_MON_THRESH)
      |=> rdata == {6'h00, $past(st.offset)})
    else $error("monitor offset read wrong");

  // a flag only rises on an edge that also moved the status
  a_flag_needs_change: assert property (
    $rose(st.flag) |-> $changed(st.below))
    else $error("flag rose without a status change");

  // falling below sets the flag only with the status now below
  a_below_trig: assert property (
    ($rose(st.flag) && $past(st.trig) == brownout_pkg::TRIG_BELOW)
      |-> st.below)
    else $error("falling trigger fired on a rise");

  // rising above sets the flag only with the status now above
  a_above_trig: assert property (
    ($rose(st.flag) && $past(st.trig) == brownout_pkg::TRIG_ABOVE)
      |-> !st.below)
    else $error("rising trigger fired on a fall");

  // a reserved trigger code must never raise the flag
  a_reserved_quiet: assert property (
    (st.trig != brownout_pkg::TRIG_BELOW
      && st.trig != brownout_pkg::TRIG_ABOVE
      && st.trig != brownout_pkg::TRIG_CROSS) |=> !$rose(st.flag))
    else $error("reserved trigger raised the flag");

  // while off only a software clear may touch the flag
  a_flag_hold_off: assert property (
    (!det_on && !clr_ev) |=> $stable(st.flag))
    else $error("flag changed while detector off");

  // the active field comes from the fuse and software cannot move it
  a_active_fixed: assert property (
    1'b1 |=> $stable(st.active_mode))
    else $error("active mode field changed outside reset");

  // the enable bit follows the written bit 0
  a_ie_write: assert property (
    (wr && addr == brownout_pkg::OFS_IRQ_CTRL)
      |=> st.ie == $past(wdata[brownout_pkg::IE_BIT]))
    else $error("interrupt enable not written");

  // a key opens a full window unless a mode write uses it at once
  a_window_len: assert property (
    (unlock_key && !(wr && addr == brownout_pkg::OFS_MODE_CTRL))
      |=> st.unlock_cnt == brownout_pkg::UNLOCK_CYCLES)
    else $error("unlock window not opened");

  // one key admits one mode write, then the window shuts
  a_window_closes: assert property (
    (wr && addr == brownout_pkg::OFS_MODE_CTRL && st.unlock_cnt != 3'h0)
      |=> st.unlock_cnt == 3'h0)
    else $error("unlock window stayed open after a write");

  // main scenarios worth seeing at least once
  c_fall_irq: cover property (
    st.trig == brownout_pkg::TRIG_BELOW && set_ev ##1 irq);
  c_cross_set: cover property (
    st.trig == brownout_pkg::TRIG_CROSS && rise_above);
  c_unlock_write: cover property (
    unlock_key ##2 (wr && addr == brownout_pkg::OFS_MODE_CTRL));
  c_set_and_clear: cover property (set_ev && clr_ev);
  c_sampled_move: cover property (
    det_on && !det_cont && sample_tick && (st.sync2 != st.below));

endmodule

//--- supply_side_model.sv
// Purpose: far side model, supply comparator and fuse loader
// Assumes: fuse values hold steady from time zero
// Notes:   comparator moves between clock edges, as a real one does
`timescale 1ns/10ps
module supply_side_model #(
  parameter logic [1:0] ACT = 2'h1,
  parameter logic [1:0] SLP = 2'h2,
  parameter logic [2:0] THR = 3'h5
) (
  // clock and bench request
  input  wire logic       clk,
  input  wire logic       below,
  // fuse loader
  output logic      [1:0] fuse_active_mode,
  output logic      [1:0] fuse_sleep_mode,
  output logic            fuse_sampfreq,
  output logic      [2:0] fuse_level,
  // comparator side
  output logic            comp_below_async,
  output logic            sample_tick
);
  logic [2:0] cnt = 3'h0;
  // fuses never move, so the reset load cannot catch a half value
  assign fuse_active_mode = ACT;
  assign fuse_sleep_mode  = SLP;
  assign fuse_sampfreq    = 1'b1;
  assign fuse_level       = THR;
  // off-edge delay exercises the two-stage synchroniser
  assign #3 comp_below_async = below;
  // one sample moment every eighth cycle
  always_ff @(posedge clk) begin
    cnt <= cnt + 3'h1;
  end
  assign sample_tick = (cnt == 3'h0);
endmodule

//--- brownout_level_monitor_ctrl_test.sv
// Purpose: self-checking bench for the brown-out register block
// Assumes: fuses active=1, sleep=2, threshold=5
// Notes:   key window reckoned from the key edge, one cycle per step
`timescale 1ns/10ps
module brownout_level_monitor_ctrl_test;
  localparam logic [1:0] FA = 2'h1;
  localparam logic [1:0] FS = 2'h2;
  localparam logic [2:0] FL = 3'h5;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic       unlock_key = 1'b0, sleep_deep = 1'b0, below = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [1:0] fuse_active_mode, fuse_sleep_mode, detector_mode;
  logic [1:0] monitor_offset;
  logic [2:0] fuse_level, detector_level;
  logic       fuse_sampfreq, comp_below_async, sample_tick;
  logic       detector_sampfreq, monitor_run, irq;
  int         bad_count = 0, check_count = 0;
  integer     seed = 32'hd2714401;
  supply_side_model #(.ACT(FA), .SLP(FS), .THR(FL)) model (.clk, .below,
    .fuse_active_mode, .fuse_sleep_mode, .fuse_sampfreq, .fuse_level,
    .comp_below_async, .sample_tick);
  brownout_level_monitor_ctrl dut (.clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .fuse_active_mode, .fuse_sleep_mode, .fuse_sampfreq,
    .fuse_level, .unlock_key, .sleep_deep, .comp_below_async,
    .sample_tick, .detector_mode, .detector_sampfreq, .detector_level,
    .monitor_offset, .monitor_run, .irq);
  // expected offset 0 contents for a given sleep field
  function logic [7:0] mode_reg(input logic [1:0] s);
    return {3'h0, 1'b1, FA, s};
  endfunction
  // does a status move from o to n set the flag under trigger t
  function logic [7:0] hit(input logic [1:0] t, input logic o, n);
    return {7'h0, (t == brownout_pkg::TRIG_CROSS && o != n) ||
      (t == brownout_pkg::TRIG_BELOW && !o && n) ||
      (t == brownout_pkg::TRIG_ABOVE && o && !n)};
  endfunction
  initial begin
    forever #10 clk = ~clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // key, then n+1 idle cycles, then the mode write
  task unlock(input int n, input logic [7:0] d);
    @(posedge clk);
    unlock_key <= 1'b1;
    @(posedge clk);
    unlock_key <= 1'b0;
    repeat (n) @(posedge clk);
    wr_reg(brownout_pkg::OFS_MODE_CTRL, d);
  endtask
  // long enough for the 3-edge comparator path to land
  task settle;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h0, mode_reg(FS));
    rd_chk(4'h1, {5'h00, FL});
    chk({5'h00, detector_level}, {5'h00, FL});
    for (int i = 8; i < 12; i++) begin
      rd_chk(i[3:0], 8'h00);
    end
    rd_chk(4'h5, 8'h00);
    wr_reg(4'h1, 8'hff);
    rd_chk(4'h1, {5'h00, FL});
    wr_reg(4'h0, 8'h00);
    rd_chk(4'h0, mode_reg(FS));
    unlock(0, 8'hff);
    rd_chk(4'h0, mode_reg(2'h3));
    unlock(0, 8'h02);
    sleep_deep <= 1'b1;
    settle;
    chk({6'h0, detector_mode},
        {6'h0, brownout_pkg::MODE_SAMPLED});
    unlock(2, 8'h00);
    unlock(4, 8'h02);
    rd_chk(4'h0, mode_reg(2'h0));
    chk({6'h0, detector_mode}, {6'h0, brownout_pkg::MODE_OFF});
    wr_reg(4'h9, 8'h01);
    below <= 1'b1;
    settle;
    chk({7'h0, monitor_run}, 8'h00);
    rd_chk(4'ha, 8'h00);
    sleep_deep <= 1'b0;
    settle;
    chk({6'h0, detector_mode}, {6'h0, FA});
    rd_chk(4'ha, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr_reg(4'h9, 8'h00);
    settle;
    chk({7'h0, irq}, 8'h00);
    below <= 1'b0;
    settle;
    wr_reg(4'ha, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr_reg(4'h9, {5'h00, t[1:0], 1'b1});
      below <= 1'b1;
      settle;
      rd_chk(4'hb, 8'h01);
      wr_reg(4'ha, 8'h00);
      rd_chk(4'ha, hit(t[1:0], 1'b0, 1'b1));
      chk({7'h0, irq}, hit(t[1:0], 1'b0, 1'b1));
      wr_reg(4'ha, 8'h01);
      rd_chk(4'ha, 8'h00);
      below <= 1'b0;
      settle;
      rd_chk(4'ha, hit(t[1:0], 1'b1, 1'b0));
      wr_reg(4'ha, 8'h01);
    end
    // mid-run reset reloads the fuses over the software sleep field
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h0, mode_reg(FS));
    chk({7'h0, irq}, 8'h00);
    // sampled standby: status and flag pick up the drop within 12 cycles
    @(posedge clk);
    sleep_deep <= 1'b1;
    below <= 1'b1;
    repeat (12) @(posedge clk);
    rd_chk(4'hb, 8'h01);
    rd_chk(4'ha, 8'h01);
    @(posedge clk);
    below <= 1'b0;
    sleep_deep <= 1'b0;
    settle;
    wr_reg(4'ha, 8'h01);
    rd_chk(4'ha, 8'h00);
    repeat (4) begin
      v = 8'($random(seed));
      wr_reg(4'h8, v);
      rd_chk(4'h8, {6'h00, v[1:0]});
      chk({6'h00, monitor_offset}, {6'h00, v[1:0]});
    end
    finish_test;
  end
endmodule
